// *** lpsm_cfg.svh ***
// constants for the low-power dram command and power-state machine
// How it works
// - command kind comes from chip select, cmd_addr_bus bits 0-3 and clock enable at rising edge.
// - each command has a rising-edge half and a falling-edge half of cmd_addr_bus.
// - activate, read, write and one-bank precharge act on the bank named by the bank-address field; burst_stop acts on the last read or write bank.
// - auto_close_flag high on read or write precharges the bank after the burst.
// - column_lsb is not sent and is always taken as zero.
// - single-bank refresh is accepted only when the device has eight banks.
// - chip select and clock enable are sampled on the rising edge only.
// - clock enable low at both edges holds the present low-power state.
// - resetting power-down exit goes idle if init_final_wait expired, else resetting.
// - leaving deepest_sleep gives power-on; a reset write then starts initialization.
// - self refresh and deepest_sleep exits follow clock enable level, not its edge history.
// - bank transitions need clock enable high twice and any exit delay elapsed.
// - activate on idle bank starts activation; active after row_to_column_time.
// - from idle, mode_reg_write_cmd and refreshes enter their busy states; all-bank forms need all idle.
// - reset from idle or power-on starts initialization and enters resetting.
// - mode_reg_read_cmd enters idle, active or resetting mode-read state by current state.
// - precharge to idle or active bank precharges; idle after row_close_time.
// - read or write to an active bank starts the matching burst.
// - during a read, read restarts, write switches, burst_stop returns to active.
// - during a write, write restarts, read switches, burst_stop returns to active.
`ifndef LPSM_CFG_SVH
`define LPSM_CFG_SVH

`define LPSM_CLK_NS      100
`define LPSM_CYC(t)      (((t) + `LPSM_CLK_NS - 1) / `LPSM_CLK_NS)
`define LPSM_BANKS       8
`define LPSM_RCD_NS      18
`define LPSM_RP_NS       18
`define LPSM_XP_NS       8
`define LPSM_XSR_NS      140
`define LPSM_INIT5_NS    10000
`define LPSM_MRW_NS      500
`define LPSM_MRR_NS      200
`define LPSM_RFCAB_NS    130
`define LPSM_RFCPB_NS    60
`define LPSM_RCD_CYC     `LPSM_CYC(`LPSM_RCD_NS)
`define LPSM_RP_CYC      `LPSM_CYC(`LPSM_RP_NS)
`define LPSM_XP_CYC      `LPSM_CYC(`LPSM_XP_NS)
`define LPSM_XSR_CYC     `LPSM_CYC(`LPSM_XSR_NS)
`define LPSM_INIT5_CYC   `LPSM_CYC(`LPSM_INIT5_NS)
`define LPSM_MRW_CYC     `LPSM_CYC(`LPSM_MRW_NS)
`define LPSM_MRR_CYC     `LPSM_CYC(`LPSM_MRR_NS)
`define LPSM_RFCAB_CYC   `LPSM_CYC(`LPSM_RFCAB_NS)
`define LPSM_RFCPB_CYC   `LPSM_CYC(`LPSM_RFCPB_NS)
`define LPSM_BURST_CYC   4
`define LPSM_MA_RESET    8'h3f
`define LPSM_OP_MRW      4'b0000
`define LPSM_OP_MRR      4'b1000
`define LPSM_OP_REFPB    4'b0100
`define LPSM_OP_REFAB    4'b1100
`define LPSM_OP_ACT      4'b??10
`define LPSM_OP_WR       4'b?001
`define LPSM_OP_RD       4'b?101
`define LPSM_OP_PRE      4'b1011
`define LPSM_OP_BST      4'b0011
`define LPSM_OP_NOP      4'b?111
`define LPSM_OP_SELF_REFRESH_STATE     3'b100
`define LPSM_OP_DPD      3'b011

`endif

// *** lpsm_pkg.sv ***
// types shared by the command and power-state machine
package lpsm_pkg;
	typedef enum logic [3:0] {
		C_NOP, C_MRW, C_MRR, C_REFPB, C_REFAB, C_ACT, C_WR, C_RD,
		C_PRE, C_BST, C_SELF_REFRESH_STATE_IN, C_DPD_IN, C_PD_IN, C_EXIT, C_KEEP, C_BAD
	} lpsm_cmd_e;
	typedef enum logic [3:0] {
		B_IDLE, B_ACTIVATING, B_ACTIVE, B_READ, B_WRITE,
		B_RD_AP, B_WR_AP, B_PRECHARGING, B_REFRESHING
	} lpsm_bank_e;
	typedef enum logic [3:0] {
		D_POWER_ON, D_RESETTING, D_NORMAL, D_MRW, D_MRR_IDLE, D_MRR_ACT, D_MRR_RST,
		D_REFAB, D_PD_ACT, D_PD_IDLE, D_PD_RST, D_SELF_REFRESH_STATE, D_DPD, D_EXIT_WAIT
	} lpsm_dev_e;
	typedef struct packed {
		lpsm_cmd_e   kind;
		logic [2:0]  bank;
		logic [14:0] row;
		logic [11:0] col;
		logic        ap;
	} lpsm_cmd_s;
endpackage

// *** lpsm_fsm.sv ***
// command decode, power-state and per-bank state machine
`timescale 1ns/1ps
`include "lpsm_cfg.svh"

module lpsm_fsm import lpsm_pkg::*; (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       reset_i,
	// command bus from the controller
	input  wire logic       cke_i,
	input  wire logic       cs_n_i,
	input  wire logic [9:0] cmd_addr_bus_i,
	input  wire logic [9:0] cmd_addr_bus_fall_i,
	// device state and accepted command
	output lpsm_dev_e        dev_state_o,
	output lpsm_bank_e [7:0] bank_state_o,
	output lpsm_cmd_s        cmd_o,
	output logic             cmd_take_o,
	output logic             cmd_illegal_o
);

	// command kind from clock enable pair, chip select and low bus bits
	function automatic lpsm_cmd_e decode(input logic kp, input logic k, input logic cs_n,
		input logic [3:0] c);
		if (!kp && !k)
			return C_KEEP;
		if (!kp && k)
			return C_EXIT;
		if (!k) begin
			if (cs_n)
				return C_PD_IN;
			if (c[2:0] == `LPSM_OP_SELF_REFRESH_STATE)
				return C_SELF_REFRESH_STATE_IN;
			if (c[2:0] == `LPSM_OP_DPD)
				return C_DPD_IN;
			return C_BAD;
		end
		if (cs_n)
			return C_NOP;
		casez (c)
			`LPSM_OP_MRW:   return C_MRW;
			`LPSM_OP_MRR:   return C_MRR;
			`LPSM_OP_REFPB: return C_REFPB;
			`LPSM_OP_REFAB: return C_REFAB;
			`LPSM_OP_ACT:   return C_ACT;
			`LPSM_OP_WR:    return C_WR;
			`LPSM_OP_RD:    return C_RD;
			`LPSM_OP_PRE:   return C_PRE;
			`LPSM_OP_BST:   return C_BST;
			default:        return C_NOP;
		endcase
	endfunction

	lpsm_dev_e        next_dev;
	lpsm_bank_e [7:0] next_bank;
	lpsm_dev_e        ret;
	lpsm_dev_e        next_ret;
	logic [3:0]       btmr [8];
	logic [3:0]       next_btmr [8];
	logic [7:0]       dtmr;
	logic [7:0]       next_dtmr;
	logic [7:0]       itmr;
	logic [7:0]       next_itmr;
	logic [2:0]       rptr;
	logic [2:0]       next_rptr;
	logic [2:0]       last_bank;
	logic [2:0]       next_last;
	logic             cke_q;
	lpsm_cmd_s        next_cmd;
	logic             next_take;
	logic             next_bad;
	lpsm_cmd_e        cur;
	logic             ok;
	logic             all_idle;
	logic             settled;
	logic             any_act;
	logic [2:0]       rb;
	logic [7:0]       ma;

	// two halves of the bus form the fields
	assign rb = cmd_addr_bus_i[9:7]; // bank field
	assign ma = {cmd_addr_bus_fall_i[1:0], cmd_addr_bus_i[9:4]};

	// next state of device, banks and timers
	always_comb begin
		next_dev  = dev_state_o;
		next_bank = bank_state_o;
		next_btmr = btmr;
		next_dtmr = dtmr;
		next_itmr = itmr;
		next_ret  = ret;
		next_rptr = rptr;
		next_last = last_bank;
		next_take = 1'b0;
		next_bad  = 1'b0;
		ok        = 1'b0;
		all_idle  = 1'b1;
		settled   = 1'b1;
		any_act   = 1'b0;
		// pins are taken at this rising edge only
		cur = decode(cke_q, cke_i, cs_n_i, cmd_addr_bus_i[3:0]);
		next_cmd.kind = cur;
		next_cmd.bank = rb;
		next_cmd.row  = {cmd_addr_bus_fall_i[9:8], cmd_addr_bus_i[6:2], cmd_addr_bus_fall_i[7:0]};
		next_cmd.col  = {cmd_addr_bus_fall_i[9:1], cmd_addr_bus_i[6:5], 1'b0};
		next_cmd.ap   = cmd_addr_bus_fall_i[0];
		// bank timers and their timed transitions
		for (int i = 0; i < 8; i++) begin
			if (btmr[i] > 4'h1)
				next_btmr[i] = btmr[i] - 4'h1;
			else if (btmr[i] == 4'h1) begin
				next_btmr[i] = 4'h0;
				unique case (bank_state_o[i])
					B_ACTIVATING, B_READ, B_WRITE: next_bank[i] = B_ACTIVE;
					B_RD_AP, B_WR_AP: begin
						next_bank[i] = B_PRECHARGING;
						next_btmr[i] = 4'(`LPSM_RP_CYC);
					end
					B_PRECHARGING, B_REFRESHING: next_bank[i] = B_IDLE;
					B_IDLE, B_ACTIVE: ;
				endcase
			end
			if (bank_state_o[i] != B_IDLE)
				all_idle = 1'b0;
			if (bank_state_o[i] != B_IDLE && bank_state_o[i] != B_ACTIVE)
				settled = 1'b0;
			if (bank_state_o[i] != B_IDLE && bank_state_o[i] != B_PRECHARGING)
				any_act = 1'b1;
		end
		if (itmr != 8'h00)
			next_itmr = itmr - 8'h01;
		if (dtmr != 8'h00)
			next_dtmr = dtmr - 8'h01;
		unique case (dev_state_o)
			D_POWER_ON: begin
				// reset write from power-on starts initialization
				if (cur == C_MRW && ma == `LPSM_MA_RESET) begin
					next_dev  = D_RESETTING;
					next_itmr = 8'(`LPSM_INIT5_CYC);
					ok        = 1'b1;
				end
			end
			D_RESETTING: begin
				if (cur == C_PD_IN) begin // resetting power-down
					next_dev = D_PD_RST;
					ok       = 1'b1;
				end else if (cur == C_MRR) begin // resetting mode read
					next_dev  = D_MRR_RST;
					next_dtmr = 8'(`LPSM_MRR_CYC);
					ok        = 1'b1;
				end else if (itmr == 8'h00)
					next_dev = D_NORMAL;
			end
			D_NORMAL: begin
				unique case (cur)
					C_PD_IN: begin
						ok       = 1'b1;
						next_dev = any_act ? D_PD_ACT : D_PD_IDLE;
					end
					C_SELF_REFRESH_STATE_IN, C_DPD_IN: if (all_idle) begin
						ok       = 1'b1;
						next_dev = (cur == C_SELF_REFRESH_STATE_IN) ? D_SELF_REFRESH_STATE : D_DPD;
					end
					// bank commands only with clock enable high twice
					C_ACT: if (bank_state_o[rb] == B_IDLE) begin // start activation
						next_bank[rb] = B_ACTIVATING;
						next_btmr[rb] = 4'(`LPSM_RCD_CYC);
						ok            = 1'b1;
					end
					C_RD, C_WR: if (bank_state_o[rb] == B_ACTIVE || bank_state_o[rb] == B_READ ||
						bank_state_o[rb] == B_WRITE) begin
						// start burst, restart or switch, auto close
						if (next_cmd.ap)
							next_bank[rb] = (cur == C_RD) ? B_RD_AP : B_WR_AP;
						else
							next_bank[rb] = (cur == C_RD) ? B_READ : B_WRITE;
						next_btmr[rb] = 4'(`LPSM_BURST_CYC);
						next_last     = rb;
						ok            = 1'b1;
					end
					C_BST: if (bank_state_o[last_bank] == B_READ || bank_state_o[last_bank] == B_WRITE) begin
						next_bank[last_bank] = B_ACTIVE;
						next_btmr[last_bank] = 4'h0;
						ok                   = 1'b1;
					end
					C_PRE: begin
						// precharge one bank or all banks
						for (int i = 0; i < 8; i++) begin
							if ((cmd_addr_bus_i[4] || 3'(i) == rb) &&
								(bank_state_o[i] == B_IDLE || bank_state_o[i] == B_ACTIVE)) begin
								next_bank[i] = B_PRECHARGING;
								next_btmr[i] = 4'(`LPSM_RP_CYC);
								ok           = 1'b1;
							end
						end
					end
					// per-bank refresh only on eight-bank parts
					C_REFPB: if (`LPSM_BANKS == 8 && bank_state_o[rptr] == B_IDLE) begin // refreshing
						next_bank[rptr] = B_REFRESHING;
						next_btmr[rptr] = 4'(`LPSM_RFCPB_CYC);
						next_rptr       = rptr + 3'h1;
						ok              = 1'b1;
					end
					// all-bank forms need every bank idle
					C_REFAB: if (all_idle) begin
						next_dev  = D_REFAB;
						next_dtmr = 8'(`LPSM_RFCAB_CYC);
						ok        = 1'b1;
					end
					C_MRW: if (all_idle) begin
						ok = 1'b1;
						if (ma == `LPSM_MA_RESET) begin // reset from idle
							next_dev  = D_RESETTING;
							next_itmr = 8'(`LPSM_INIT5_CYC);
						end else begin
							next_dev  = D_MRW;
							next_dtmr = 8'(`LPSM_MRW_CYC);
						end
					end
					// mode read from idle or row active
					C_MRR: if (settled) begin
						next_dev  = all_idle ? D_MRR_IDLE : D_MRR_ACT;
						next_dtmr = 8'(`LPSM_MRR_CYC);
						ok        = 1'b1;
					end
					default: ;
				endcase
			end
			D_MRW, D_MRR_IDLE, D_MRR_ACT, D_REFAB: begin
				if (dtmr <= 8'h01)
					next_dev = D_NORMAL;
			end
			D_MRR_RST: begin
				if (dtmr <= 8'h01)
					next_dev = D_RESETTING;
			end
			// low at both edges keeps the low-power state
			D_PD_ACT, D_PD_IDLE, D_PD_RST: begin
				if (cur == C_EXIT && cs_n_i) begin
					next_dev  = D_EXIT_WAIT;
					next_dtmr = 8'(`LPSM_XP_CYC);
					// resetting exit depends on init wait
					next_ret  = (dev_state_o == D_PD_RST && itmr != 8'h00) ? D_RESETTING : D_NORMAL;
					ok        = 1'b1;
				end
			end
			// self refresh exit follows the clock enable level
			D_SELF_REFRESH_STATE: begin
				if (cke_i) begin
					next_dev  = D_EXIT_WAIT;
					next_dtmr = 8'(`LPSM_XSR_CYC);
					next_ret  = D_NORMAL;
					ok        = 1'b1;
				end
			end
			// deep sleep exit returns to power-on
			D_DPD: begin
				if (cke_i) begin
					next_dev = D_POWER_ON;
					ok       = 1'b1;
				end
			end
			// exit delay must elapse before bank commands
			D_EXIT_WAIT: begin
				if (dtmr <= 8'h01)
					next_dev = ret;
			end
		endcase
		next_take = ok;
		if (!ok && cur != C_NOP && cur != C_KEEP)
			next_bad = 1'b1;
		if (!ok)
			next_cmd = cmd_o;
	end

	// state registers
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			dev_state_o   <= D_POWER_ON;
			bank_state_o  <= {8{B_IDLE}};
			ret           <= D_NORMAL;
			dtmr          <= 8'h00;
			itmr          <= 8'h00;
			rptr          <= 3'h0;
			last_bank     <= 3'h0;
			cke_q         <= 1'b0;
			cmd_o         <= '0;
			cmd_take_o    <= 1'b0;
			cmd_illegal_o <= 1'b0;
			for (int i = 0; i < 8; i++)
				btmr[i] <= 4'h0;
		end else begin
			dev_state_o   <= next_dev;
			bank_state_o  <= next_bank;
			ret           <= next_ret;
			dtmr          <= next_dtmr;
			itmr          <= next_itmr;
			rptr          <= next_rptr;
			last_bank     <= next_last;
			cke_q         <= cke_i; // previous clock enable level
			cmd_o         <= next_cmd;
			cmd_take_o    <= next_take;
			cmd_illegal_o <= next_bad;
			btmr          <= next_btmr;
		end
	end

endmodule

// *** lpsm_fsm_props.sv ***
// concurrent checks on the ports of the command and power-state machine
`timescale 1ns/1ps
module lpsm_fsm_props import lpsm_pkg::*; (
	// clock and reset
	input wire logic       core_clk_i,
	input wire logic       reset_i,
	// command bus
	input wire logic       cke_i,
	input wire logic       cs_n_i,
	input wire logic [9:0] cmd_addr_bus_i,
	input wire logic [9:0] cmd_addr_bus_fall_i,
	// results
	input wire lpsm_dev_e        dev_state_o,
	input wire lpsm_bank_e [7:0] bank_state_o,
	input wire lpsm_cmd_s        cmd_o,
	input wire logic             cmd_take_o,
	input wire logic             cmd_illegal_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	logic rw;
	logic lp;
	// accepted column access and low-power states
	assign rw = cmd_take_o && (cmd_o.kind == C_RD || cmd_o.kind == C_WR);
	assign lp = dev_state_o inside {D_PD_ACT, D_PD_IDLE, D_PD_RST, D_SELF_REFRESH_STATE, D_DPD};
	property p_hold; !$past(cke_i) && !cke_i && lp |=> $stable(dev_state_o); endproperty
	a_hold: assert property (p_hold) else $error("low-power state left with clock enable low");
	property p_act; cmd_take_o && cmd_o.kind == C_ACT |-> bank_state_o[cmd_o.bank] == B_ACTIVATING
		##1 bank_state_o[cmd_o.bank] == B_ACTIVE; endproperty
	a_act: assert property (p_act) else $error("activation sequence wrong");
	property p_col; rw |-> cmd_o.col[0] == 1'b0; endproperty
	a_col: assert property (p_col) else $error("column lsb not zero");
	property p_burst; rw && !cmd_o.ap |-> bank_state_o[cmd_o.bank] == (cmd_o.kind == C_RD ? B_READ : B_WRITE);
		endproperty
	a_burst: assert property (p_burst) else $error("burst state wrong");
	property p_ap; rw && cmd_o.ap |-> ##[1:8] bank_state_o[cmd_o.bank] == B_PRECHARGING; endproperty
	a_ap: assert property (p_ap) else $error("no precharge after auto-close access");
	property p_pre; cmd_take_o && cmd_o.kind == C_PRE |-> bank_state_o[cmd_o.bank] == B_PRECHARGING
		##[1:3] bank_state_o[cmd_o.bank] == B_IDLE; endproperty
	a_pre: assert property (p_pre) else $error("precharge sequence wrong");
	// bank commands only in normal state
	property p_bank; cmd_take_o && cmd_o.kind inside {C_ACT, C_RD, C_WR, C_PRE, C_BST}
		|-> $past(dev_state_o) == D_NORMAL && $past(cke_i) && $past(cke_i, 2); endproperty
	a_bank: assert property (p_bank) else $error("bank command taken outside normal");
	property p_dpd; $past(dev_state_o) == D_DPD && dev_state_o != D_DPD |-> dev_state_o == D_POWER_ON;
		endproperty
	a_dpd: assert property (p_dpd) else $error("deep sleep exit not to power-on");
	property p_self_refresh_state; $past(cke_i) && !cke_i && !cs_n_i && cmd_addr_bus_i[2:0] == 3'b100
		&& dev_state_o == D_NORMAL && bank_state_o == '0 |=> dev_state_o == D_SELF_REFRESH_STATE; endproperty
	a_self_refresh_state: assert property (p_self_refresh_state) else $error("self refresh not entered");
	property p_mrr; cmd_take_o && cmd_o.kind == C_MRR
		|-> dev_state_o inside {D_MRR_IDLE, D_MRR_ACT, D_MRR_RST}; endproperty
	a_mrr: assert property (p_mrr) else $error("mode read state wrong");
	// refresh of all banks only from all idle
	property p_refab; cmd_take_o && cmd_o.kind == C_REFAB
		|-> dev_state_o == D_REFAB && $past(bank_state_o) == '0; endproperty
	a_refab: assert property (p_refab) else $error("all-bank refresh state wrong");
endmodule
bind lpsm_fsm lpsm_fsm_props u_props (.core_clk_i, .reset_i, .cke_i, .cs_n_i, .cmd_addr_bus_i,
	.cmd_addr_bus_fall_i, .dev_state_o, .bank_state_o, .cmd_o, .cmd_take_o, .cmd_illegal_o);

// *** lpsm_ctrl_model.sv ***
// controller-side model that places requests on the command bus
`timescale 1ns/1ps
module lpsm_ctrl_model (
	// clock and request from bench
	input  wire logic       core_clk_i,
	input  wire logic       go_i,
	input  wire logic       cke_req_i,
	input  wire logic       cs_n_req_i,
	input  wire logic [9:0] rise_req_i,
	input  wire logic [9:0] fall_req_i,
	// command bus
	output logic            cke_o,
	output logic            cs_n_o,
	output logic [9:0]      rise_o,
	output logic [9:0]      fall_o
);
	initial begin
		cke_o = 1'b0;
		cs_n_o = 1'b1;
		rise_o = 10'h000;
		fall_o = 10'h000;
	end
	// both halves together, clock enable held, deselect between
	always @(posedge core_clk_i) begin
		if (go_i) begin
			cke_o <= cke_req_i;
			cs_n_o <= cs_n_req_i;
			rise_o <= rise_req_i;
			fall_o <= fall_req_i;
		end else begin
			cs_n_o <= 1'b1;
			rise_o <= ~rise_o;
			fall_o <= ~fall_o;
		end
	end
endmodule

// *** lpsm_fsm_tb_top.sv ***
// self-checking bench for the command and power-state machine
`timescale 1ns/1ps
module lpsm_fsm_tb_top import lpsm_pkg::*;;
	logic             clk, rst, go, ck, cs;
	logic [9:0]       ri, fa;
	wire logic        cke, cs_n;
	wire logic [9:0]  ca_r, ca_f;
	lpsm_dev_e        dev;
	lpsm_bank_e [7:0] burst_stop;
	lpsm_cmd_s        cmd;
	logic             take, ill;
	logic [14:0]      row;
	int               eb [8];
	int               miscompares, checked;
	logic [9:0]       mr [3] = '{10'h010, 10'h008, 10'h00c};
	int               md [3] = '{D_MRW, D_MRR_IDLE, D_REFAB};
	// clock and instances
	always #50 clk = ~clk;
	lpsm_ctrl_model ctrl (.core_clk_i(clk), .go_i(go), .cke_req_i(ck), .cs_n_req_i(cs), .rise_req_i(ri),
		.fall_req_i(fa), .cke_o(cke), .cs_n_o(cs_n), .rise_o(ca_r), .fall_o(ca_f));
	lpsm_fsm DUT (.core_clk_i(clk), .reset_i(rst), .cke_i(cke), .cs_n_i(cs_n), .cmd_addr_bus_i(ca_r),
		.cmd_addr_bus_fall_i(ca_f), .dev_state_o(dev), .bank_state_o(burst_stop), .cmd_o(cmd), .cmd_take_o(take),
		.cmd_illegal_o(ill));
	// comparisons and verdict
	task automatic chk_ev(input logic [15:0] g, e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_st(input logic [15:0] g, e); chk_ev(g, e); endtask
	task automatic wrap_up;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk_banks;
		for (int i = 0; i < 8; i++) chk_st(burst_stop[i], eb[i]);
	endtask
	// one request, result looked at after the sampling edge; t 2 leaves pulses unchecked
	task automatic send(input logic k, c, input logic [9:0] r, f, input int t, d);
		@(posedge clk);
		go <= 1'b1;
		ck <= k;
		cs <= c;
		ri <= r;
		fa <= f;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk) #1;
		if (t < 2) chk_ev(take, t == 1);
		if (t < 2) chk_ev(ill, t == 0);
		if (d >= 0) chk_st(dev, d);
		if (d >= 0) chk_banks();
	endtask
	task automatic wait_dev(input int d, n);
		for (int i = 0; i < n && dev !== lpsm_dev_e'(d); i++) @(posedge clk) #1;
		chk_st(dev, d);
	endtask
	task automatic wait_bank(input int b, s);
		for (int i = 0; i < 12 && burst_stop[b] !== lpsm_bank_e'(s); i++) @(posedge clk) #1;
		eb[b] = s;
		chk_banks();
	endtask
	task automatic act(input logic [2:0] b);
		row = 15'($urandom);
		eb[b] = B_ACTIVATING;
		send(1'b1, 1'b0, {b, row[12:8], 2'b10}, {row[14:13], row[7:0]}, 1, D_NORMAL);
		chk_ev(cmd.row, row);
		chk_ev(cmd.bank, b);
		chk_ev(cmd.kind, C_ACT);
		@(posedge clk) #1;
		eb[b] = B_ACTIVE;
		chk_banks();
	endtask
	task automatic rw(input logic [2:0] b, input logic w, a, input int es);
		logic [11:0] c;
		c = 12'($urandom);
		eb[b] = es;
		send(1'b1, 1'b0, {b, c[2:1], 2'b00, !w, 2'b01}, {c[11:3], a}, 1, D_NORMAL);
		chk_ev(cmd.col, {c[11:1], 1'b0});
		chk_ev(cmd.ap, a);
		chk_ev(cmd.kind, w ? C_WR : C_RD);
	endtask
	// watchdog
	initial begin
		#1000000;
		miscompares++;
		wrap_up();
	end
	// main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		go = 1'b0;
		ck = 1'b0;
		cs = 1'b1;
		ri = 10'h000;
		fa = 10'h000;
		void'($urandom(52744));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		send(1'b1, 1'b1, 10'h000, 10'h000, 0, D_POWER_ON);
		send(1'b1, 1'b0, 10'h082, 10'h000, 0, D_POWER_ON);
		send(1'b1, 1'b0, 10'h3f0, 10'h000, 1, D_RESETTING);
		send(1'b1, 1'b0, 10'h008, 10'h000, 1, D_MRR_RST);
		wait_dev(D_RESETTING, 8);
		send(1'b0, 1'b1, 10'h000, 10'h000, 2, D_PD_RST);
		send(1'b0, 1'b0, 10'($urandom), 10'($urandom), 2, D_PD_RST);
		send(1'b1, 1'b1, 10'h000, 10'h000, 2, -1);
		wait_dev(D_RESETTING, 4);
		wait_dev(D_NORMAL, 200);
		act(3'd5);
		rw(3'd5, 1'b0, 1'b0, B_READ);
		rw(3'd5, 1'b1, 1'b0, B_WRITE);
		rw(3'd5, 1'b0, 1'b0, B_READ);
		eb[5] = B_ACTIVE;
		send(1'b1, 1'b0, 10'h003, 10'h000, 1, D_NORMAL);
		rw(3'd5, 1'b1, 1'b1, B_WR_AP);
		wait_bank(5, B_IDLE);
		eb[2] = B_PRECHARGING;
		send(1'b1, 1'b0, 10'h10b, 10'h000, 1, D_NORMAL);
		wait_bank(2, B_IDLE);
		send(1'b1, 1'b0, 10'h185, 10'h000, 0, D_NORMAL);
		for (int i = 0; i < 3; i++) begin
			send(1'b1, 1'b0, mr[i], 10'h000, 1, md[i]);
			wait_dev(D_NORMAL, 20);
		end
		eb[0] = B_REFRESHING;
		send(1'b1, 1'b0, 10'h004, 10'h000, 1, D_NORMAL);
		wait_dev(D_NORMAL, 4);
		wait_bank(0, B_IDLE);
		// precharge of every bank at once
		for (int i = 0; i < 8; i++) eb[i] = B_PRECHARGING;
		send(1'b1, 1'b0, 10'h01b, 10'h000, 1, D_NORMAL);
		@(posedge clk) #1;
		for (int i = 0; i < 8; i++) eb[i] = B_IDLE;
		chk_banks();
		act(3'd1);
		send(1'b0, 1'b1, 10'h000, 10'h000, 2, D_PD_ACT);
		send(1'b0, 1'b0, 10'($urandom), 10'($urandom), 2, D_PD_ACT);
		send(1'b1, 1'b1, 10'h000, 10'h000, 2, D_EXIT_WAIT);
		wait_dev(D_NORMAL, 4);
		eb[1] = B_PRECHARGING;
		send(1'b1, 1'b0, 10'h08b, 10'h000, 1, D_NORMAL);
		wait_bank(1, B_IDLE);
		send(1'b0, 1'b0, 10'h004, 10'h000, 2, D_SELF_REFRESH_STATE);
		send(1'b0, 1'b0, 10'($urandom), 10'($urandom), 2, D_SELF_REFRESH_STATE);
		send(1'b1, 1'b1, 10'h000, 10'h000, 2, -1);
		wait_dev(D_NORMAL, 6);
		send(1'b0, 1'b0, 10'h003, 10'h000, 2, D_DPD);
		send(1'b1, 1'b1, 10'h000, 10'h000, 2, -1);
		wait_dev(D_POWER_ON, 4);
		send(1'b1, 1'b0, 10'h3f0, 10'h000, 1, D_RESETTING);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk_st(dev, D_POWER_ON);
		wrap_up();
	end
endmodule
